// file: verilog/smbe_slave_port.sv
// two-wire slave port with memory array, control sector and write cycle
// Functional notes
// - ignore bus until start condition seen
// - stop ends transaction, returns to standby
// - ninth clock: receiver pulls data low
// - ack slave address only when fields match
// - ack all write bytes except bad address
// - read: release, sample ack, continue or stop
// - upper nibble must equal type code
// - strap bits must match strap pins
// - sector bit picks array or registers
// - address lsb: 1 read, 0 write
// - writes need write-permit latch set
// - latch-only write starts no write cycle
// - byte write order; stop launches cycle
// - busy write cycle: ignore bus, release
// - protected block: no data ack
// - page write wraps within 16 bytes
// - early or mid-byte stop discards write
// - no ack while write cycle busy
// - address counter points past last word
// - reset: standby, latch clear, pin input
// - write only after proper bit sequence
`timescale 1ns/100ps
`include "smbe_map.svh"

module smbe_slave_port
  import smbe_pkg::*;
#(
  parameter logic [3:0] TYPE_ID = `SMBE_TYPE_ID_DFLT,
  parameter int unsigned WR_CYCLES = `SMBE_TWC_CYC
) (
  // clocks and reset
  input wire logic i_clk_sys,
  input wire logic i_clk_link,
  input wire logic i_rst_b,
  // serial bus pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  // straps and protection level
  input wire logic i_addr_strap_low,
  input wire logic i_addr_strap_high,
  input wire logic [1:0] i_block_protect,
  // status
  output smbe_pkg::smbe_stat_t o_status
);
  import smbe_pkg::*;

  // -------------------------------------------------------------
  // declarations
  // -------------------------------------------------------------
  logic [5:0] pin_s1_r;
  logic [5:0] pin_s2_r;
  logic [3:0] strap_s1_r;
  logic [3:0] strap_s2_r;
  logic scl_d_r;
  logic sda_d_r;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  smbe_state_t st_r;
  smbe_kind_t kind_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic sda_oe_r;
  logic sda_out_r;
  logic sector_r;
  logic [7:0] addr_r;
  logic got_data_r;
  logic [7:0] page_buf_r [`SMBE_PAGE_BYTES];
  logic [15:0] mask_r;
  logic [3:0] page_r;
  logic cr0_hit_r;
  logic [7:0] cr0_val_r;
  logic wpl_r;
  logic req_tgl_r;
  logic done_tgl;
  logic done_s1_r;
  logic done_s2_r;
  logic busy;
  smbe_stat_t stat_r;
  logic [7:0] mem [`SMBE_MEM_DEPTH];
  logic [7:0] regs_r [`SMBE_REG_DEPTH];
  smbe_saddr_t sa;
  logic byte_done;
  logic sa_match;
  logic prot_hit;
  logic [7:0] rd_byte;
  logic commit;
  logic [7:0] addr_inpage;

  // -------------------------------------------------------------
  // pin synchronisers, link domain
  // -------------------------------------------------------------
  always_ff @(posedge i_clk_link or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_s1_r <= 6'h3;
      pin_s2_r <= 6'h3;
      strap_s1_r <= 4'h0;
      strap_s2_r <= 4'h0;
      done_s1_r <= 1'b0;
      done_s2_r <= 1'b0;
    end else begin
      pin_s1_r <= {i_block_protect, 2'b00, i_scl, i_sda};
      pin_s2_r <= pin_s1_r;
      strap_s1_r <= {2'b00, i_addr_strap_high, i_addr_strap_low};
      strap_s2_r <= strap_s1_r;
      done_s1_r <= done_tgl;
      done_s2_r <= done_s1_r;
    end
  end

  assign scl_s = pin_s2_r[1];
  assign sda_s = pin_s2_r[0];

  always_ff @(posedge i_clk_link or negedge i_rst_b) begin
    if (!i_rst_b) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_d_r;
  assign scl_fall = ~scl_s & scl_d_r;
  assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s;
  // busy from launch until the timer's done toggle comes back
  assign busy = req_tgl_r ^ done_s2_r;

  // -------------------------------------------------------------
  // byte decode
  // -------------------------------------------------------------
  assign sa = smbe_saddr_t'(shift_r);
  assign byte_done = (st_r == ST_RX) && scl_fall && (bit_cnt_r == 4'h8);
  assign sa_match = (sa.type_identifier_field == TYPE_ID)
                  && (sa.strap_match_bits == strap_s2_r[1:0])
                  && !busy;
  assign addr_inpage = {addr_r[7:4], addr_r[3:0] + 4'h1};

  always_comb begin
    unique case (pin_s2_r[5:4])
      2'b00: prot_hit = 1'b0;
      2'b01: prot_hit = (addr_r >= `SMBE_BP_QTR_BASE);
      2'b10: prot_hit = (addr_r >= `SMBE_BP_HALF_BASE);
      2'b11: prot_hit = 1'b1;
    endcase
  end

  // sector bit routes reads to array or registers
  assign rd_byte = (sector_r == `SMBE_SECTOR_MEM) ? mem[addr_r] : regs_r[addr_r[2:0]];

  // a full data byte plus its ack and a clean byte boundary are needed;
  // the stop's own clock rise has already shifted one bit in
  assign commit = stop_det && (st_r == ST_RX) && (kind_r == K_DATA)
                && (bit_cnt_r == 4'h1) && got_data_r;

  // -------------------------------------------------------------
  // protocol state machine
  // -------------------------------------------------------------
  always_ff @(posedge i_clk_link or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r <= ST_IDLE;
      kind_r <= K_SADDR;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      sda_oe_r <= 1'b0;
      sector_r <= 1'b0;
      got_data_r <= 1'b0;
    end else if (start_det && !busy) begin
      // a repeated start reopens the address phase
      st_r <= ST_RX;
      kind_r <= K_SADDR;
      bit_cnt_r <= 4'h0;
      sda_oe_r <= 1'b0;
      got_data_r <= 1'b0;
    end else if (start_det || stop_det) begin
      st_r <= (start_det) ? ST_WAIT : ST_IDLE;
      sda_oe_r <= 1'b0;
    end else begin
      unique case (st_r)
        ST_IDLE, ST_WAIT: begin
          sda_oe_r <= 1'b0;
        end
        ST_RX: begin
          if (scl_rise && bit_cnt_r != 4'h8) begin
            shift_r <= {shift_r[6:0], sda_s};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (byte_done) begin
            unique case (kind_r)
              K_SADDR: begin
                sector_r <= sa.sector_select_bit;
                st_r <= sa_match ? ST_ACK : ST_WAIT;
                sda_oe_r <= sa_match;
              end
              K_WORD: begin
                st_r <= ST_ACK;
                sda_oe_r <= 1'b1;
              end
              default: begin
                st_r <= (sector_r == `SMBE_SECTOR_MEM && prot_hit) ? ST_WAIT : ST_ACK;
                sda_oe_r <= !(sector_r == `SMBE_SECTOR_MEM && prot_hit);
              end
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bit_cnt_r <= 4'h0;
            if (kind_r == K_SADDR && sa.direction_bit == `SMBE_DIR_READ) begin
              st_r <= ST_TX;
              tx_r <= rd_byte;
              sda_oe_r <= ~rd_byte[7];
            end else begin
              st_r <= ST_RX;
              sda_oe_r <= 1'b0;
              kind_r <= (kind_r == K_SADDR) ? K_WORD : K_DATA;
              got_data_r <= got_data_r | (kind_r == K_DATA);
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_r == 4'h7) begin
              st_r <= ST_TXACK;
              sda_oe_r <= 1'b0;
            end else begin
              tx_r <= {tx_r[6:0], 1'b0};
              sda_oe_r <= ~tx_r[6];
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
          end
        end
        ST_TXACK: begin
          if (scl_rise && sda_s) begin
            st_r <= ST_WAIT;
          end else if (scl_fall) begin
            st_r <= ST_TX;
            bit_cnt_r <= 4'h0;
            tx_r <= rd_byte;
            sda_oe_r <= ~rd_byte[7];
          end
        end
      endcase
    end
  end

  // -------------------------------------------------------------
  // address counter
  // -------------------------------------------------------------
  always_ff @(posedge i_clk_link or negedge i_rst_b) begin
    if (!i_rst_b) begin
      addr_r <= 8'h00;
    end else if (!start_det && !stop_det) begin
      if (byte_done && kind_r == K_WORD) begin
        addr_r <= shift_r;
      end else if (st_r == ST_ACK && scl_fall && kind_r == K_DATA) begin
        addr_r <= addr_inpage;
      end else if (scl_fall && ((st_r == ST_ACK && kind_r == K_SADDR
                   && sa.direction_bit == `SMBE_DIR_READ) || st_r == ST_TXACK)) begin
        addr_r <= addr_r + 8'h01;
      end
    end
  end

  // -------------------------------------------------------------
  // page buffer; later bytes overwrite earlier ones in the page
  // -------------------------------------------------------------
  always_ff @(posedge i_clk_link or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mask_r <= 16'h0000;
      page_r <= 4'h0;
      cr0_hit_r <= 1'b0;
      cr0_val_r <= 8'h00;
      for (int i = 0; i < `SMBE_PAGE_BYTES; i++) begin
        page_buf_r[i] <= 8'h00;
      end
    end else if (start_det) begin
      mask_r <= 16'h0000;
      cr0_hit_r <= 1'b0;
    end else if (byte_done && kind_r == K_DATA) begin
      page_buf_r[addr_r[3:0]] <= shift_r;
      mask_r[addr_r[3:0]] <= 1'b1;
      page_r <= addr_r[7:4];
      if (sector_r != `SMBE_SECTOR_MEM && addr_r == `SMBE_CR0_ADDR) begin
        cr0_hit_r <= 1'b1;
        cr0_val_r <= shift_r;
      end
    end
  end

  // -------------------------------------------------------------
  // commit, write-permit latch and cycle launch
  // -------------------------------------------------------------
  always_ff @(posedge i_clk_link or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wpl_r <= 1'b0;
      req_tgl_r <= 1'b0;
    end else if (commit) begin
      if (cr0_hit_r && (cr0_val_r == `SMBE_WPL_ON || cr0_val_r == `SMBE_WPL_OFF)) begin
        wpl_r <= cr0_val_r[7];
      end else if (wpl_r) begin
        req_tgl_r <= ~req_tgl_r;
      end
    end
  end

  // the array holds no reset value; only committed pages change it
  always_ff @(posedge i_clk_link) begin
    if (commit && wpl_r && !cr0_hit_r && sector_r == `SMBE_SECTOR_MEM) begin
      for (int i = 0; i < `SMBE_PAGE_BYTES; i++) begin
        if (mask_r[i]) begin
          mem[{page_r, 4'(i)}] <= page_buf_r[i];
        end
      end
    end
  end

  always_ff @(posedge i_clk_link or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int i = 0; i < `SMBE_REG_DEPTH; i++) begin
        regs_r[i] <= 8'h00;
      end
    end else if (commit && wpl_r && !cr0_hit_r && sector_r != `SMBE_SECTOR_MEM) begin
      for (int i = 0; i < `SMBE_REG_DEPTH; i++) begin
        if (mask_r[i] && page_r == 4'h0) begin
          regs_r[i] <= page_buf_r[i];
        end
      end
    end
  end

  // -------------------------------------------------------------
  // write cycle timer in the system domain
  // -------------------------------------------------------------
  smbe_nvw_timer #(
    .WR_CYCLES(WR_CYCLES)
  ) u_timer (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_req_tgl(req_tgl_r),
    .o_done_tgl(done_tgl)
  );

  // -------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------
  always_ff @(posedge i_clk_link or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sda_out_r <= 1'b0;
      stat_r <= '0;
    end else begin
      sda_out_r <= 1'b0;
      stat_r <= '{busy: busy, write_permit_latch: wpl_r};
    end
  end

  assign o_sda_out = sda_out_r;
  assign o_sda_oe = sda_oe_r;
  assign o_status = stat_r;

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  default clocking cb @(posedge i_clk_link);
  endclocking
  default disable iff (!i_rst_b);

  a_busy_no_ack: assert property (
    (start_det && busy)
      |=> (st_r == ST_WAIT) && !sda_oe_r)
    else $error("address acked while write cycle busy");

  a_addr_match_ack: assert property (
    (byte_done && kind_r == K_SADDR && sa_match && !stop_det && !start_det)
      |=> (st_r == ST_ACK) && sda_oe_r)
    else $error("matching address not acked");

  a_type_mismatch: assert property (
    (byte_done && kind_r == K_SADDR && sa.type_identifier_field != TYPE_ID)
      |=> !sda_oe_r)
    else $error("wrong type code acked");

  a_strap_mismatch: assert property (
    (byte_done && kind_r == K_SADDR && sa.strap_match_bits != strap_s2_r[1:0])
      |=> !sda_oe_r)
    else $error("wrong strap bits acked");

  a_protect_nack: assert property (
    (byte_done && kind_r == K_DATA && sector_r == `SMBE_SECTOR_MEM && prot_hit)
      |=> !sda_oe_r)
    else $error("protected data byte acked");

  a_page_wrap: assert property (
    (st_r == ST_ACK && scl_fall && kind_r == K_DATA && !stop_det && !start_det)
      |=> addr_r[7:4] == $past(addr_r[7:4]))
    else $error("page write left its page");

  a_abort_no_write: assert property (
    (stop_det && st_r == ST_RX && bit_cnt_r > 4'h1) |=> $stable(req_tgl_r))
    else $error("mid-byte stop launched a write");

  a_latch_no_cycle: assert property (
    (commit && cr0_hit_r && cr0_val_r == `SMBE_WPL_ON) |=> $stable(req_tgl_r) ##1 !busy)
    else $error("latch write started a write cycle");

  a_permit_gate: assert property (
    $changed(req_tgl_r) |-> $past(wpl_r) && $past(commit))
    else $error("write cycle without permit latch");

  a_tx_release: assert property (
    (st_r == ST_TXACK) |-> !sda_oe_r)
    else $error("data line held in read ack slot");

  a_busy_quiet: assert property (
    (busy && st_r == ST_IDLE) |=> !sda_oe_r)
    else $error("data line driven while busy");
endmodule

// file: include/smbe_map.svh
// constants for the two-wire slave memory port
`ifndef SMBE_MAP_SVH
`define SMBE_MAP_SVH

// arbitrary neutral type identifier, not tied to any real part
`define SMBE_TYPE_ID_DFLT 4'h5
`define SMBE_PAGE_W 4
`define SMBE_PAGE_BYTES 16
`define SMBE_MEM_DEPTH 256
`define SMBE_REG_DEPTH 8
`define SMBE_CR0_ADDR 8'h00
`define SMBE_WPL_ON 8'h80
`define SMBE_WPL_OFF 8'h00
`define SMBE_BP_QTR_BASE 8'hC0
`define SMBE_BP_HALF_BASE 8'h80
`define SMBE_SECTOR_MEM 1'b0
`define SMBE_DIR_READ 1'b1
`define SMBE_TWC_NS 5000000
`define SMBE_SYS_NS 50
`define SMBE_TWC_CYC (`SMBE_TWC_NS / `SMBE_SYS_NS)

`endif

// file: include/smbe_pkg.sv
// types shared by the slave memory port
package smbe_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_TXACK,
    ST_WAIT
  } smbe_state_t;

  typedef enum logic [1:0] {
    K_SADDR,
    K_WORD,
    K_DATA
  } smbe_kind_t;

  typedef struct packed {
    logic [3:0] type_identifier_field;
    logic [1:0] strap_match_bits;
    logic sector_select_bit;
    logic direction_bit;
  } smbe_saddr_t;

  typedef struct packed {
    logic busy;
    logic write_permit_latch;
  } smbe_stat_t;

endpackage

// file: verilog/smbe_nvw_timer.sv
// nonvolatile write cycle timer, system clock domain, toggle handshake
`timescale 1ns/100ps
`include "smbe_map.svh"

module smbe_nvw_timer #(
  parameter int unsigned WR_CYCLES = `SMBE_TWC_CYC
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // handshake with the link domain
  input wire logic i_req_tgl,
  output logic o_done_tgl
);
  logic req_s1_r;
  logic req_s2_r;
  logic req_s3_r;
  logic [31:0] cnt_r;
  logic run_r;
  logic done_tgl_r;

  // -------------------------------------------------------------
  // request synchroniser
  // -------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      req_s1_r <= 1'b0;
      req_s2_r <= 1'b0;
      req_s3_r <= 1'b0;
    end else begin
      req_s1_r <= i_req_tgl;
      req_s2_r <= req_s1_r;
      req_s3_r <= req_s2_r;
    end
  end

  // -------------------------------------------------------------
  // cycle timer
  // -------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_r <= 32'h0;
      run_r <= 1'b0;
      done_tgl_r <= 1'b0;
    end else if (req_s2_r != req_s3_r) begin
      run_r <= 1'b1;
      cnt_r <= 32'(WR_CYCLES);
    end else if (run_r) begin
      if (cnt_r <= 32'h1) begin
        run_r <= 1'b0;
        done_tgl_r <= ~done_tgl_r;
      end else begin
        cnt_r <= cnt_r - 32'h1;
      end
    end
  end

  assign o_done_tgl = done_tgl_r;

  a_timer_length: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (req_s2_r != req_s3_r) |=> run_r [*2])
    else $error("write cycle ended too early");
endmodule

// file: tb/smbe_bus_master.sv
// behavioural two-wire bus master that drives the serial clock and pulls the data line
`timescale 1ns/100ps
module smbe_bus_master #(
  parameter int QTR = 4
) (
  // clock and wired data level
  input wire logic i_clk_sys,
  input wire logic i_sda,
  // bus drive
  output logic o_scl,
  output logic o_sda_low
);
  // clock stands high between frames, data released to the pull-up
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end

  task automatic q(input int n = 1);
    repeat (n * QTR) @(negedge i_clk_sys);
  endtask

  // start or repeated start: data falls while clock is high
  task automatic start();
    o_sda_low = 1'b0;
    q();
    o_scl = 1'b1;
    q();
    o_sda_low = 1'b1;
    q();
    o_scl = 1'b0;
    q();
  endtask

  // stop: data rises while clock is high, clock then left high
  task automatic stop();
    o_sda_low = 1'b1;
    q();
    o_scl = 1'b1;
    q();
    o_sda_low = 1'b0;
    q();
  endtask

  // data only changes while the clock is low
  task automatic put_bit(input logic b);
    o_sda_low = ~b;
    q();
    o_scl = 1'b1;
    q(2);
    o_scl = 1'b0;
    q();
  endtask

  task automatic get_bit(output logic b);
    o_sda_low = 1'b0;
    q();
    o_scl = 1'b1;
    q();
    b = i_sda;
    q();
    o_scl = 1'b0;
    q();
  endtask

  // msb first; a short count models an aborted byte with no ack slot
  task automatic wbyte(input logic [7:0] d, input int n, output logic ack);
    logic a;
    a = 1'b1;
    for (int i = 7; i > 7 - n; i--) begin
      put_bit(d[i]);
    end
    if (n == 8) begin
      get_bit(a);
    end
    ack = ~a;
  endtask

  // master acks to continue, leaves the slot released to end the read
  task automatic rbyte(input logic more, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      get_bit(d[i]);
    end
    put_bit(~more);
  endtask
endmodule

// file: tb/smbe_slave_port_tb_top.sv
// self-checking bench for the two-wire slave memory port
`timescale 1ns/100ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin bad_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module smbe_slave_port_tb_top;
  import smbe_pkg::*;
  localparam logic [3:0] TID = 4'h9; // arbitrary type code for the bench
  logic clk = 1'b0, clk_link = 1'b0, rst_b = 1'b0, scl, sda_low, sda_oe, sda_out, sda_w;
  logic [1:0] prot = 2'b00, strap = 2'b01;
  smbe_stat_t status;
  logic [7:0] mem_exp [16];
  int bad_count = 0, total_checks = 0;
  assign sda_w = ~(sda_low | sda_oe);

  initial forever #25 clk = ~clk;
  initial begin
    #3.7;
    forever #7.5 clk_link = ~clk_link;
  end

  smbe_slave_port #(.TYPE_ID(TID), .WR_CYCLES(300)) u_dut (
    .i_clk_sys(clk), .i_clk_link(clk_link), .i_rst_b(rst_b), .i_scl(scl), .i_sda(sda_w),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_addr_strap_low(strap[0]),
    .i_addr_strap_high(strap[1]), .i_block_protect(prot), .o_status(status));
  smbe_bus_master u_mst (.i_clk_sys(clk), .i_sda(sda_w), .o_scl(scl), .o_sda_low(sda_low));

  // ---------------------------------------------------------------
  // shared bus steps
  // ---------------------------------------------------------------
  function automatic logic [7:0] sa(input logic sec, input logic dir);
    return {TID, strap, sec, dir};
  endfunction

  task automatic send(input logic [7:0] b, input logic exp_ack);
    logic ack;
    u_mst.wbyte(b, 8, ack);
    `CHK(ack, exp_ack)
  endtask

  task automatic rd_chk(input logic [7:0] exp, input logic more);
    logic [7:0] d;
    u_mst.rbyte(more, d);
    `CHK(d, exp)
  endtask

  // bounded ack poll; leaves a write address acked on the bus
  task automatic poll();
    logic ack;
    for (int i = 0; i < 8; i++) begin
      u_mst.start();
      u_mst.wbyte(sa(1'b0, 1'b0), 8, ack);
      if (ack) break;
      u_mst.stop();
    end
    `CHK(ack, 1'b1)
    if (ack !== 1'b1) begin
      close_out();
    end
  endtask

  task automatic rd_at(input logic [7:0] a, input logic [7:0] exp);
    poll();
    send(a, 1'b1);
    u_mst.start();
    send(sa(1'b0, 1'b1), 1'b1);
    rd_chk(exp, 1'b0);
    u_mst.stop();
  endtask

  task automatic settle();
    repeat (6) @(negedge clk);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    `CHK(sda_oe, 1'b0)
    `CHK(sda_out, 1'b0)
    `CHK(status, 2'b00)
  endtask

  task automatic t_bad_addr();
    logic [7:0] bad [3];
    bad = '{{TID ^ 4'h8, 2'b01, 2'b00}, {TID, 2'b10, 2'b00}, {TID ^ 4'h1, 2'b11, 2'b01}};
    foreach (bad[i]) begin
      u_mst.start();
      send(bad[i], 1'b0);
      send(8'h00, 1'b0);
      u_mst.stop();
    end
    // the strap pins move, so a hard-wired match would be caught here
    strap = 2'b10;
    settle();
    u_mst.start();
    send(sa(1'b0, 1'b0), 1'b1);
    send(8'h10, 1'b1);
    u_mst.stop();
    strap = 2'b01;
    settle();
    `CHK(status.busy, 1'b0)
  endtask

  task automatic t_latch(input logic [7:0] v);
    u_mst.start();
    send(sa(1'b1, 1'b0), 1'b1);
    send(8'h00, 1'b1);
    send(v, 1'b1);
    u_mst.stop();
    settle();
    `CHK(status.write_permit_latch, v[7])
    `CHK(status.busy, 1'b0)
  endtask

  task automatic t_page();
    logic ack;
    u_mst.start();
    send(sa(1'b0, 1'b0), 1'b1);
    send(8'h0A, 1'b1);
    for (int i = 0; i < 20; i++) begin
      mem_exp[(10 + i) % 16] = 8'h30 + 8'(i);
      send(8'h30 + 8'(i), 1'b1);
    end
    u_mst.stop();
    settle();
    `CHK(status.busy, 1'b1)
    u_mst.start();
    u_mst.wbyte(sa(1'b0, 1'b0), 8, ack);
    `CHK(ack, 1'b0)
    `CHK(sda_oe, 1'b0)
    u_mst.stop();
    poll();
    send(8'h00, 1'b1);
    u_mst.start();
    send(sa(1'b0, 1'b1), 1'b1);
    for (int i = 0; i < 12; i++) begin
      rd_chk(mem_exp[i], i < 11);
    end
    u_mst.stop();
    u_mst.start();
    send(sa(1'b0, 1'b1), 1'b1);
    rd_chk(mem_exp[12], 1'b0);
    u_mst.stop();
  endtask

  task automatic t_protect();
    prot = 2'b11;
    u_mst.start();
    send(sa(1'b0, 1'b0), 1'b1);
    send(8'h02, 1'b1);
    send(8'hEE, 1'b0);
    u_mst.stop();
    prot = 2'b00;
    rd_at(8'h02, mem_exp[2]);
    // register sector word 01h must read back apart from array word 01h
    u_mst.start();
    send(sa(1'b1, 1'b0), 1'b1);
    send(8'h01, 1'b1);
    send(8'h5A, 1'b1);
    u_mst.stop();
    poll();
    u_mst.stop();
    u_mst.start();
    send(sa(1'b1, 1'b0), 1'b1);
    send(8'h01, 1'b1);
    u_mst.start();
    send(sa(1'b1, 1'b1), 1'b1);
    rd_chk(8'h5A, 1'b0);
    u_mst.stop();
  endtask

  task automatic t_abort();
    logic ack;
    u_mst.start();
    send(sa(1'b0, 1'b0), 1'b1);
    send(8'h03, 1'b1);
    u_mst.wbyte(8'hFF, 4, ack);
    u_mst.stop();
    settle();
    `CHK(status.busy, 1'b0)
    rd_at(8'h03, mem_exp[3]);
  endtask

  task automatic t_nolatch();
    t_latch(8'h00);
    u_mst.start();
    send(sa(1'b0, 1'b0), 1'b1);
    send(8'h04, 1'b1);
    send(8'h99, 1'b1);
    u_mst.stop();
    rd_at(8'h04, mem_exp[4]);
  endtask

  // ---------------------------------------------------------------
  // sequence and verdict
  // ---------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(negedge clk);
    t_reset();
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    t_reset();
    t_bad_addr();
    t_latch(8'h80);
    t_page();
    t_protect();
    t_abort();
    t_nolatch();
    close_out();
  end

  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    $display("unexpected at %0t: run did not finish", $time);
    close_out();
  end
endmodule
